// [hpm_map.vh]
// Purpose: register map, fields, reset values and timing for mode control
// Assumes: 8-bit registers reached over the serial register port
// Notes:   included by the mode controller and its slot memory
`ifndef HPM_MAP_VH
`define HPM_MAP_VH

`define HPM_REG_MODE      8'h01
`define HPM_REG_RT_AMP    8'h02
`define HPM_REG_LIB       8'h03
`define HPM_REG_SLOT_LO   8'h04
`define HPM_REG_SLOT_HI   8'h0b
`define HPM_REG_FIRE      8'h0c
`define HPM_REG_CTRL_A    8'h1b
`define HPM_REG_CTRL_B    8'h1c
`define HPM_REG_CTRL_C    8'h1d

`define HPM_MODE_SEL_HI   2
`define HPM_MODE_SEL_LO   0
`define HPM_MODE_HOLD_BIT 6
`define HPM_FIRE_BIT      0
`define HPM_BIDIR_BIT     7
`define HPM_OPEN_LOOP_BIT 0
`define HPM_ANALOG_BIT    1

`define HPM_SEL_INT       3'h0
`define HPM_SEL_EDGE      3'h1
`define HPM_SEL_LEVEL     3'h2
`define HPM_SEL_EXT_IN    3'h3
`define HPM_SEL_RT        3'h5

`define HPM_RST_MODE      8'h40
`define HPM_RST_RT_AMP    8'h00
`define HPM_RST_LIB       8'h00
`define HPM_RST_SLOT      8'h00
`define HPM_RST_CTRL_A    8'h00
`define HPM_RST_CTRL_B    8'h80
`define HPM_RST_CTRL_C    8'h00

`define HPM_SLOTS         8
`define HPM_CLK_MHZ       10
`define HPM_EFFECT_US     1000
`define HPM_EFFECT_CYCLES (`HPM_EFFECT_US * `HPM_CLK_MHZ)

`endif

// [hpm_slot_mem.v]
// Purpose: eight-entry waveform slot store with two registered read ports
// Assumes: one write port, read data one cycle after address
// Notes:   port a serves register reads, port b the sequencer
`timescale 1ns/1ns
`include "hpm_map.vh"
module hpm_slot_mem #(
	parameter DEPTH = `HPM_SLOTS,
	parameter AW    = 3,
	parameter DW    = 8
) (
	input  wire          clk,
	input  wire          rst,
	input  wire          ce,
	input  wire          wr_en,
	input  wire [AW-1:0] wr_addr,
	input  wire [DW-1:0] wr_data,
	input  wire [AW-1:0] rda_addr,
	output reg  [DW-1:0] rda_data,
	input  wire [AW-1:0] rdb_addr,
	output reg  [DW-1:0] rdb_data
);
	reg [DW-1:0] mem_q [0:DEPTH-1];
	genvar g;

	generate
		for (g = 0; g < DEPTH; g = g + 1) begin : g_slot
			always @(posedge clk) begin
				if (rst) begin
					mem_q[g] <= `HPM_RST_SLOT;
				end else if (ce && wr_en && wr_addr == g) begin
					mem_q[g] <= wr_data;
				end
			end
		end
	endgenerate

	always @(posedge clk) begin
		if (rst) begin
			rda_data <= {DW{1'b0}};
			rdb_data <= {DW{1'b0}};
		end else if (ce) begin
			rda_data <= mem_q[rda_addr];
			rdb_data <= mem_q[rdb_addr];
		end
	end
endmodule

// [hpm_mode_ctrl.v]
// Purpose: serial register port, mode decode and playback start control
// Assumes: pins are asynchronous and pass two flops; 10 MHz clock
// Notes:   effect playback length is a stand-in for the waveform engine
//
// Contract
// - enable pin is honoured at any time, no power-up gating.
// - writing 0x00 to mode register clears the hold state.
// - reset defaults to closed-loop bidirectional; controls at 0x1c and 0x1d change it.
// - low power when hold bit set or enable pin low.
// - mode select and hold bit are taken in one write.
// - select 0 internal, 1 edge, 2 level trigger playback.
// - effect taken from slot 0x04 or sequence of slots 0x04-0x0b.
// - internal trigger: setting fire bit starts the effect sequence.
// - external trigger pin pulse starts the effect sequence.
// - same sequence may be fired again without reloading slots.
// - select 5 enters real-time playback.
// - each written real-time amplitude is driven out.
// - select 3 enters pulse-width or analog input playback.
// - pulse-width versus analog choice comes from control_c.
// - enable pin is active high.
// - trigger pin tied low is harmless when all control is serial.
`timescale 1ns/1ns
`include "hpm_map.vh"
module hpm_mode_ctrl #(
	parameter [6:0] DEV_ADDR      = 7'h2a,
	parameter       EFFECT_CYCLES = `HPM_EFFECT_CYCLES
) (
	input  wire       clk,
	input  wire       rst,
	input  wire       ce,
	input  wire       enable_pin,
	input  wire       input_trigger_pin,
	input  wire       scl_in,
	input  wire       sda_in,
	output reg        sda_out,
	output reg        sda_oe_n,
	output reg        low_power,
	output reg        playing,
	output reg  [7:0] effect_index,
	output reg  [7:0] library_select,
	output reg        real_time_playback,
	output reg  [7:0] drive_amplitude,
	output reg        ext_input_active,
	output reg        analog_select,
	output reg        open_loop,
	output reg        bidirectional
);
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_AACK = 3'h2;
	localparam ST_WR   = 3'h3;
	localparam ST_WACK = 3'h4;
	localparam ST_RD   = 3'h5;
	localparam ST_RACK = 3'h6;
	localparam SQ_IDLE = 2'h0;
	localparam SQ_WAIT = 2'h1;
	localparam SQ_TAKE = 2'h2;
	localparam SQ_PLAY = 2'h3;
	localparam [31:0] EFF_CNT_W = EFFECT_CYCLES;
	localparam [23:0] EFF_CNT = EFF_CNT_W[23:0];
	function is_slot;
		input [7:0] a;
		is_slot = (a >= `HPM_REG_SLOT_LO) && (a <= `HPM_REG_SLOT_HI);
	endfunction
	reg  [2:0] pin_s1_q, pin_s2_q, pin_d_q;
	wire       en_s = pin_s2_q[0];
	wire       trg_s = pin_s2_q[1];
	wire       sda_s = pin_s2_q[2];
	reg        scl_s1_q, scl_s2_q, scl_d_q;
	wire       scl_rise = scl_s2_q & ~scl_d_q;
	wire       scl_fall = ~scl_s2_q & scl_d_q;
	wire       i2c_start = scl_s2_q & scl_d_q & pin_d_q[2] & ~sda_s;
	wire       i2c_stop = scl_s2_q & scl_d_q & ~pin_d_q[2] & sda_s;
	wire       trg_rise = trg_s & ~pin_d_q[1];
	reg  [2:0] st_q;
	reg  [3:0] bit_q;
	reg  [7:0] sh_q, tx_q, ptr_q;
	reg        first_q, nack_q, wr_en;
	reg  [7:0] wr_addr, wr_data;
	reg  [7:0] mode_q, rt_q, lib_q, ca_q, cb_q, cc_q;
	reg        busy_q;
	reg  [1:0] sq_q;
	reg  [2:0] slot_q;
	reg [23:0] cnt_q;
	reg  [7:0] idx_q;
	wire [7:0] slot_rda, slot_rdb;
	reg  [7:0] rd_mux;
	wire [2:0] sel = mode_q[`HPM_MODE_SEL_HI:`HPM_MODE_SEL_LO];
	wire       hold = mode_q[`HPM_MODE_HOLD_BIT];
	wire       lp = hold | ~en_s;
	wire       mode_wr = wr_en && wr_addr == `HPM_REG_MODE;
	wire       fire_wr = wr_en && wr_addr == `HPM_REG_FIRE;
	wire       fire_set = fire_wr & wr_data[`HPM_FIRE_BIT];
	wire       trig_mode = sel == `HPM_SEL_EDGE || sel == `HPM_SEL_LEVEL;
	// start on fire bit or trigger pin; idle pin low never starts
	wire       go_req = ~lp && ((sel == `HPM_SEL_INT && fire_set) ||
	                            (trig_mode && trg_rise));
	wire       stop_req = lp || (fire_wr && !wr_data[`HPM_FIRE_BIT]) ||
	                      (sel == `HPM_SEL_LEVEL && !trg_s) ||
	                      !(sel == `HPM_SEL_INT || trig_mode);
	hpm_slot_mem u_slots (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.wr_en    (wr_en && is_slot(wr_addr)),
		.wr_addr  (wr_addr[2:0] - 3'h4),
		.wr_data  (wr_data),
		.rda_addr (ptr_q[2:0] - 3'h4),
		.rda_data (slot_rda),
		.rdb_addr (slot_q),
		.rdb_data (slot_rdb)
	);
	// pin synchronisers
	always @(posedge clk) begin
		if (rst) begin
			pin_s1_q <= 3'h4;
			pin_s2_q <= 3'h4;
			pin_d_q  <= 3'h4;
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_d_q  <= 1'b1;
		end else if (ce) begin
			pin_s1_q <= {sda_in, input_trigger_pin, enable_pin};
			pin_s2_q <= pin_s1_q;
			pin_d_q  <= pin_s2_q;
			scl_s1_q <= scl_in;
			scl_s2_q <= scl_s1_q;
			scl_d_q  <= scl_s2_q;
		end
	end
	always @* begin
		rd_mux = 8'h00;
		if (is_slot(ptr_q)) begin
			rd_mux = slot_rda;
		end else begin
			case (ptr_q)
				`HPM_REG_MODE:   rd_mux = mode_q;
				`HPM_REG_RT_AMP: rd_mux = rt_q;
				`HPM_REG_LIB:    rd_mux = lib_q;
				`HPM_REG_FIRE:   rd_mux = {7'h00, busy_q};
				`HPM_REG_CTRL_A: rd_mux = ca_q;
				`HPM_REG_CTRL_B: rd_mux = cb_q;
				`HPM_REG_CTRL_C: rd_mux = cc_q;
				default:         rd_mux = 8'h00;
			endcase
		end
	end
	// serial register port: pointer byte first, then auto-increment
	always @(posedge clk) begin
		if (rst) begin
			st_q     <= ST_IDLE;
			bit_q    <= 4'h0;
			sh_q     <= 8'h00;
			tx_q     <= 8'h00;
			ptr_q    <= 8'h00;
			first_q  <= 1'b0;
			nack_q   <= 1'b0;
			sda_out  <= 1'b0;
			sda_oe_n <= 1'b1;
			wr_en    <= 1'b0;
			wr_addr  <= 8'h00;
			wr_data  <= 8'h00;
		end else if (ce) begin
			wr_en <= 1'b0;
			if (i2c_start) begin
				st_q     <= ST_ADDR;
				bit_q    <= 4'h0;
				sda_oe_n <= 1'b1;
			end else if (i2c_stop) begin
				st_q     <= ST_IDLE;
				sda_oe_n <= 1'b1;
			end else begin
				case (st_q)
					ST_ADDR, ST_WR: begin
						if (scl_rise) begin
							sh_q  <= {sh_q[6:0], sda_s};
							bit_q <= bit_q + 4'h1;
						end else if (scl_fall && bit_q == 4'h8) begin
							bit_q <= 4'h0;
							if (st_q == ST_ADDR) begin
								if (sh_q[7:1] == DEV_ADDR) begin
									st_q     <= ST_AACK;
									nack_q   <= sh_q[0];
									sda_oe_n <= 1'b0;
								end else begin
									st_q <= ST_IDLE;
								end
							end else begin
								st_q     <= ST_WACK;
								sda_oe_n <= 1'b0;
								first_q  <= 1'b0;
								if (first_q) begin
									ptr_q <= sh_q;
								end else begin
									wr_en   <= 1'b1;
									wr_addr <= ptr_q;
									wr_data <= sh_q;
									ptr_q   <= ptr_q + 8'h01;
								end
							end
						end
					end
					ST_AACK: begin
						if (scl_fall) begin
							if (nack_q) begin
								st_q     <= ST_RD;
								tx_q     <= rd_mux;
								sda_oe_n <= rd_mux[7];
								ptr_q    <= ptr_q + 8'h01;
								nack_q   <= 1'b0;
							end else begin
								st_q     <= ST_WR;
								first_q  <= 1'b1;
								sda_oe_n <= 1'b1;
							end
						end
					end
					ST_WACK: begin
						if (scl_fall) begin
							st_q     <= ST_WR;
							sda_oe_n <= 1'b1;
						end
					end
					ST_RD: begin
						if (scl_fall) begin
							if (bit_q == 4'h7) begin
								st_q     <= ST_RACK;
								bit_q    <= 4'h0;
								sda_oe_n <= 1'b1;
							end else begin
								bit_q    <= bit_q + 4'h1;
								tx_q     <= {tx_q[6:0], 1'b0};
								sda_oe_n <= tx_q[6];
							end
						end
					end
					ST_RACK: begin
						if (scl_rise) begin
							nack_q <= sda_s;
						end else if (scl_fall) begin
							if (nack_q) begin
								st_q <= ST_IDLE;
							end else begin
								st_q     <= ST_RD;
								tx_q     <= rd_mux;
								sda_oe_n <= rd_mux[7];
								ptr_q    <= ptr_q + 8'h01;
							end
						end
					end
					default: begin
						st_q     <= ST_IDLE;
						sda_oe_n <= 1'b1;
					end
				endcase
			end
		end
	end
	// configuration registers
	always @(posedge clk) begin
		if (rst) begin
			mode_q <= `HPM_RST_MODE;
			rt_q   <= `HPM_RST_RT_AMP;
			lib_q  <= `HPM_RST_LIB;
			ca_q   <= `HPM_RST_CTRL_A;
			cb_q   <= `HPM_RST_CTRL_B;
			cc_q   <= `HPM_RST_CTRL_C;
		end else if (ce && wr_en) begin
			case (wr_addr)
				`HPM_REG_MODE:   mode_q <= wr_data;
				`HPM_REG_RT_AMP: rt_q   <= wr_data;
				`HPM_REG_LIB:    lib_q  <= wr_data;
				`HPM_REG_CTRL_A: ca_q   <= wr_data;
				`HPM_REG_CTRL_B: cb_q   <= wr_data;
				`HPM_REG_CTRL_C: cc_q   <= wr_data;
				default:         mode_q <= mode_q;
			endcase
		end
	end
	// sequencer walks slots until a zero index or the last slot
	always @(posedge clk) begin
		if (rst) begin
			sq_q   <= SQ_IDLE;
			busy_q <= 1'b0;
			slot_q <= 3'h0;
			cnt_q  <= 24'h000000;
			idx_q  <= 8'h00;
		end else if (ce) begin
			if (go_req) begin
				// restart from first slot; start wins over stop
				sq_q   <= SQ_WAIT;
				busy_q <= 1'b1;
				slot_q <= 3'h0;
				idx_q  <= 8'h00;
			end else if (stop_req || mode_wr) begin
				sq_q   <= SQ_IDLE;
				busy_q <= 1'b0;
				idx_q  <= 8'h00;
			end else begin
				case (sq_q)
					SQ_IDLE: busy_q <= 1'b0;
					SQ_WAIT: sq_q <= SQ_TAKE;
					SQ_TAKE: begin
						if (slot_rdb == 8'h00) begin
							sq_q   <= SQ_IDLE;
							busy_q <= 1'b0;
							idx_q  <= 8'h00;
						end else begin
							sq_q  <= SQ_PLAY;
							idx_q <= slot_rdb;
							cnt_q <= EFF_CNT - 24'h000001;
						end
					end
					SQ_PLAY: begin
						if (cnt_q != 24'h000000) begin
							cnt_q <= cnt_q - 24'h000001;
						end else if (slot_q == 3'h7) begin
							sq_q   <= SQ_IDLE;
							busy_q <= 1'b0;
							idx_q  <= 8'h00;
						end else begin
							sq_q   <= SQ_WAIT;
							slot_q <= slot_q + 3'h1;
						end
					end
					default: begin
						sq_q   <= SQ_IDLE;
						busy_q <= 1'b0;
					end
				endcase
			end
		end
	end
	// registered outputs
	always @(posedge clk) begin
		if (rst) begin
			low_power          <= 1'b1;
			playing            <= 1'b0;
			effect_index       <= 8'h00;
			library_select     <= `HPM_RST_LIB;
			real_time_playback <= 1'b0;
			drive_amplitude    <= 8'h00;
			ext_input_active   <= 1'b0;
			analog_select      <= 1'b0;
			open_loop          <= 1'b0;
			bidirectional      <= 1'b1;
		end else if (ce) begin
			low_power          <= lp;
			playing            <= busy_q;
			effect_index       <= idx_q;
			library_select     <= lib_q;
			real_time_playback <= ~lp && sel == `HPM_SEL_RT;
			drive_amplitude    <= (~lp && sel == `HPM_SEL_RT) ? rt_q : 8'h00;
			ext_input_active   <= ~lp && sel == `HPM_SEL_EXT_IN;
			analog_select      <= cc_q[`HPM_ANALOG_BIT];
			open_loop          <= cc_q[`HPM_OPEN_LOOP_BIT];
			bidirectional      <= cb_q[`HPM_BIDIR_BIT];
		end
	end
endmodule

// [hpm_mode_ctrl_asserts.sv]
// Purpose: port checks of the mode controller
// Assumes: one clock, sync reset, ce gates all state
// Notes:   bound from tb_top
`timescale 1ns/1ns
module hpm_mode_ctrl_asserts #(
	parameter EFFECT_CYCLES = 10000
) (
	input wire       clk,
	input wire       rst,
	input wire       ce,
	input wire       enable_pin,
	input wire       low_power,
	input wire       playing,
	input wire [7:0] effect_index,
	input wire       real_time_playback,
	input wire [7:0] drive_amplitude,
	input wire       ext_input_active
);
	reg [15:0] run_q;
	reg [7:0]  idx_q;
	// cycles one index has stood while playing
	always @(posedge clk) if (ce) begin
		idx_q <= effect_index;
		if (rst || !playing || effect_index != idx_q)
			run_q <= 16'h0000;
		else
			run_q <= run_q + 16'h0001;
	end
	default clocking dc @(posedge clk); endclocking
	default disable iff (rst || !ce);
	chk_lp_enable: assert property ((!enable_pin) [*4] |-> low_power)
		else $error("low power missing with enable low");
	chk_lp_exit: assert property ($fell(low_power) |-> enable_pin && $past(enable_pin))
		else $error("low power left with enable low");
	chk_lp_stops: assert property (low_power [*3] |-> !playing)
		else $error("playing in low power");
	chk_start_power: assert property ($rose(playing) |-> !low_power)
		else $error("playback started in low power");
	chk_idle_index: assert property ((!playing) [*3] |-> effect_index == 8'h00)
		else $error("index shown while idle");
	chk_effect_len: assert property (run_q <= EFFECT_CYCLES + 4)
		else $error("effect outlasts its length");
	chk_mode_excl: assert property (low_power [*2] |-> !real_time_playback && !ext_input_active)
		else $error("playback mode active in low power");
	chk_amp_idle: assert property ((!real_time_playback) [*2] |-> drive_amplitude == 8'h00)
		else $error("amplitude driven outside real time");
	chk_rt_ext: assert property (real_time_playback |-> !ext_input_active)
		else $error("two input modes at once");
	cover property ($rose(playing));
	cover property ($rose(real_time_playback));
	cover property ($rose(ext_input_active));
endmodule

// [hpm_host_model.sv]
// Purpose: serial controller model of the host
// Assumes: open-drain sda with pull-up; 10-cycle phases
// Notes:   tasks called from tb_top
`timescale 1ns/1ns
module hpm_host_model #(
	parameter [6:0] ADDR = 7'h2a
) (
	input  wire clk,
	input  wire sda_line,
	output reg  scl,
	output reg  sda
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task hold(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task bitx(input b, output r);
		begin
			hold(5);
			sda <= b;
			hold(5);
			scl <= 1'b1;
			hold(10);
			r = sda_line;
			scl <= 1'b0;
		end
	endtask
	// start is (1,0), stop is (0,1)
	task cond(input a, input b);
		begin
			hold(5);
			sda <= a;
			hold(5);
			scl <= 1'b1;
			hold(10);
			sda <= b;
			hold(10);
			if (!b)
				scl <= 1'b0;
		end
	endtask
	// send v, or receive with v=ff; last bit is ack slot
	task xfer(input [7:0] v, output [7:0] q, output ack);
		integer i;
		reg     r;
		begin
			for (i = 7; i >= 0; i = i - 1)
				bitx(v[i], q[i]);
			bitx(1'b1, r);
			ack = !r;
		end
	endtask
	task wr(input [7:0] a, input [7:0] d, output ok);
		reg [7:0] q;
		reg       k1;
		reg       k2;
		reg       k3;
		begin
			cond(1'b1, 1'b0);
			xfer({ADDR, 1'b0}, q, k1);
			xfer(a, q, k2);
			xfer(d, q, k3);
			cond(1'b0, 1'b1);
			ok = k1 & k2 & k3;
		end
	endtask
	task rd(input [7:0] a, output [7:0] d, output ok);
		reg [7:0] q;
		reg       k1;
		reg       k2;
		reg       k3;
		begin
			cond(1'b1, 1'b0);
			xfer({ADDR, 1'b0}, q, k1);
			xfer(a, q, k2);
			cond(1'b1, 1'b0);
			xfer({ADDR, 1'b1}, q, k3);
			xfer(8'hff, d, k1);
			cond(1'b0, 1'b1);
			ok = k2 & k3;
		end
	endtask
endmodule

// [tb_top.sv]
// Purpose: register-level tests of the mode controller
// Assumes: EFFECT_CYCLES shortened to 200
// Notes: calibration memory taken as programmed
`timescale 1ns/1ns
module tb_top;
	reg        clk;
	reg        rst;
	reg        enable_pin;
	reg        trig;
	reg        ok;
	reg  [7:0] rv;
	wire       scl;
	wire       host_sda;
	wire       sda_line;
	wire       sda_out;
	wire       sda_oe_n;
	wire       low_power;
	wire       playing;
	wire [7:0] effect_index;
	wire [7:0] library_select;
	wire       real_time_playback;
	wire [7:0] drive_amplitude;
	wire       ext_input_active;
	wire       analog_select;
	wire       open_loop;
	wire       bidirectional;
	integer    err_total;
	integer    n_compared;
	integer    cyc;
	assign sda_line = host_sda & (sda_oe_n | sda_out);
	initial clk = 1'b0;
	always #50 clk = ~clk;
	hpm_mode_ctrl #(.EFFECT_CYCLES(200)) uut (
		.clk                (clk),
		.rst                (rst),
		.ce                 (1'b1),
		.enable_pin         (enable_pin),
		.input_trigger_pin  (trig),
		.scl_in             (scl),
		.sda_in             (sda_line),
		.sda_out            (sda_out),
		.sda_oe_n           (sda_oe_n),
		.low_power          (low_power),
		.playing            (playing),
		.effect_index       (effect_index),
		.library_select     (library_select),
		.real_time_playback (real_time_playback),
		.drive_amplitude    (drive_amplitude),
		.ext_input_active   (ext_input_active),
		.analog_select      (analog_select),
		.open_loop          (open_loop),
		.bidirectional      (bidirectional)
	);
	hpm_host_model host (
		.clk      (clk),
		.sda_line (sda_line),
		.scl      (scl),
		.sda      (host_sda)
	);
	task summarize;
		begin
			if (err_total == 0 && n_compared > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	task cmp(input [7:0] got, input [7:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("unexpected at %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task w(input [7:0] a, input [7:0] d);
		begin
			host.wr(a, d, ok);
			cmp({7'h00, ok}, 8'h01);
		end
	endtask
	task r(input [7:0] a, input [7:0] exp);
		begin
			host.rd(a, rv, ok);
			cmp({7'h00, ok}, 8'h01);
			cmp(rv, exp);
		end
	endtask
	task seq_check;
		begin
			tick(20);
			cmp({7'h00, playing}, 8'h01);
			cmp(effect_index, 8'h05);
			tick(200);
			cmp(effect_index, 8'h09);
			tick(200);
			cmp(effect_index, 8'h00);
			cmp({7'h00, playing}, 8'h00);
		end
	endtask
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 40000) begin
			err_total = err_total + 1;
			summarize;
		end
	end
	initial begin
		rst = 1'b1;
		enable_pin = 1'b0;
		trig = 1'b0;
		err_total = 0;
		n_compared = 0;
		cyc = 0;
		tick(10);
		rst <= 1'b0;
		tick(1);
		cmp({6'h00, low_power, bidirectional}, 8'h03);
		enable_pin <= 1'b1;
		tick(2500);
		cmp({7'h00, low_power}, 8'h01);
		r(8'h01, 8'h40);
		r(8'h1c, 8'h80);
		w(8'h01, 8'h00);
		tick(5);
		cmp({7'h00, low_power}, 8'h00);
		enable_pin <= 1'b0;
		tick(6);
		cmp({7'h00, low_power}, 8'h01);
		enable_pin <= 1'b1;
		tick(6);
		cmp({7'h00, low_power}, 8'h00);
		w(8'h03, 8'h07);
		cmp(library_select, 8'h07);
		w(8'h1d, 8'h03);
		cmp({6'h00, analog_select, open_loop}, 8'h03);
		w(8'h1c, 8'h00);
		cmp({7'h00, bidirectional}, 8'h00);
		w(8'h04, 8'h05);
		w(8'h05, 8'h09);
		w(8'h0c, 8'h01);
		seq_check;
		r(8'h0c, 8'h00);
		w(8'h0c, 8'h01);
		seq_check;
		w(8'h0c, 8'h01);
		enable_pin <= 1'b0;
		tick(6);
		cmp({6'h00, low_power, playing}, 8'h02);
		cmp(effect_index, 8'h00);
		enable_pin <= 1'b1;
		tick(6);
		w(8'h01, 8'h01);
		trig <= 1'b1;
		tick(20);
		trig <= 1'b0;
		seq_check;
		w(8'h01, 8'h02);
		trig <= 1'b1;
		tick(30);
		cmp(effect_index, 8'h05);
		trig <= 1'b0;
		tick(10);
		cmp({7'h00, playing}, 8'h00);
		w(8'h01, 8'h45);
		tick(3);
		cmp({6'h00, low_power, real_time_playback}, 8'h02);
		r(8'h01, 8'h45);
		w(8'h01, 8'h05);
		tick(3);
		cmp({6'h00, low_power, real_time_playback}, 8'h01);
		w(8'h02, 8'h80);
		cmp(drive_amplitude, 8'h80);
		w(8'h02, 8'h33);
		cmp(drive_amplitude, 8'h33);
		w(8'h01, 8'h03);
		tick(3);
		cmp({6'h00, ext_input_active, real_time_playback}, 8'h02);
		w(8'h30, 8'h5a);
		r(8'h30, 8'h00);
		summarize;
	end
endmodule
bind hpm_mode_ctrl hpm_mode_ctrl_asserts #(.EFFECT_CYCLES(EFFECT_CYCLES)) chk_i (
	.clk                (clk),
	.rst                (rst),
	.ce                 (ce),
	.enable_pin         (enable_pin),
	.low_power          (low_power),
	.playing            (playing),
	.effect_index       (effect_index),
	.real_time_playback (real_time_playback),
	.drive_amplitude    (drive_amplitude),
	.ext_input_active   (ext_input_active)
);
